// [banked_data_memory_map_tb.sv]
// self-checking bench for the banked data memory map
// assumes the core model as the only driver of the request bus
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module banked_data_memory_map_tb;
  import bdmm_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wdt_pd_reset_i = 1'b0;
  logic [7:0] ro_status_i = 8'h5a;
  logic req_valid;
  bdmm_req_t req;
  logic [7:0] rdata;
  logic [7:0] nv_ctrl;
  logic [7:0] rd_v;
  logic [7:0] rd_v2;
  logic rvalid;
  logic bank_sel;
  logic got;
  logic [7:0] ram_a [4] = '{8'h80, 8'h81, 8'hc0, 8'hff};
  int err_total = 0;
  int n_compared = 0;
  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;
  bdmm_map u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wdt_pd_reset_i(wdt_pd_reset_i),
    .req_valid_i(req_valid), .req_i(req), .ro_status_i(ro_status_i), .rdata_o(rdata),
    .rvalid_o(rvalid), .bank_sel_o(bank_sel), .nv_ctrl_o(nv_ctrl));
  bdmm_core_model u_core (.core_clk_i(core_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .req_valid_o(req_valid), .req_o(req));
  // byte write or bit operation, no read answer expected
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input bdmm_op_t op = BDMM_OP_WRITE, input logic [2:0] b = 3'h0);
    u_core.acc(1'b0, op, a, d, b, rd_v, got);
    `CHK(got, 1'b0)
  endtask : wr
  // read and compare the answer
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_core.acc(1'b1, BDMM_OP_NONE, a, 8'h00, 3'h0, rd_v, got);
    `CHK(got, 1'b1)
    `CHK(rd_v, exp)
  endtask : rd_chk
  // verdict and end of run
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    @(negedge core_clk_i);
    `CHK(bank_sel, 1'b0)
    `CHK(nv_ctrl, NV_CTRL_RST)
    rd_chk(BANK_PTR_ADDR, 8'h00);
    foreach (ram_a[i]) wr(ram_a[i], ram_a[i] ^ 8'h5c);
    foreach (ram_a[i]) rd_chk(ram_a[i], ram_a[i] ^ 8'h5c);
    wr(8'h81, 8'h00, BDMM_OP_BSET, 3'h1);
    rd_chk(8'h81, 8'hdf);
    wr(8'h81, 8'hff, BDMM_OP_BCLR, 3'h7);
    rd_chk(8'h81, 8'h5f);
    u_core.acc2('{rd: 1'b0, op: BDMM_OP_BSET, addr: 8'hc0, wdata: 8'h00, bit_sel: 3'h0},
      '{rd: 1'b0, op: BDMM_OP_BSET, addr: 8'hc0, wdata: 8'h00, bit_sel: 3'h1}, rd_v, rd_v2);
    rd_chk(8'hc0, 8'h9f);
    u_core.acc2('{rd: 1'b0, op: BDMM_OP_WRITE, addr: 8'hc0, wdata: 8'h42, bit_sel: 3'h0},
      '{rd: 1'b1, op: BDMM_OP_NONE, addr: 8'hc0, wdata: 8'h00, bit_sel: 3'h0}, rd_v, rd_v2);
    `CHK(rd_v2, 8'h42)
    wr(SCRATCH_ADDR, 8'h3c);
    wr(8'h10, 8'hff);
    rd_chk(8'h10, ZERO_BYTE);
    rd_chk(SCRATCH_ADDR, 8'h3c);
    rd_chk(8'h80, 8'hdc);
    wr(RO_STAT_ADDR, 8'hff);
    rd_chk(RO_STAT_ADDR, 8'h5a);
    ro_status_i = 8'ha3;
    rd_chk(RO_STAT_ADDR, 8'ha3);
    wr(BANK_PTR_ADDR, 8'hff);
    rd_chk(BANK_PTR_ADDR, 8'h01);
    `CHK(bank_sel, 1'b1)
    rd_chk(NV_CTRL_ADDR, ZERO_BYTE);
    wr(IND_PTR_ADDR, NV_CTRL_ADDR);
    rd_chk(IND_PTR_ADDR, NV_CTRL_ADDR);
    wr(IND_WIN_ADDR, 8'h77);
    @(negedge core_clk_i);
    `CHK(nv_ctrl, 8'h77)
    rd_chk(IND_WIN_ADDR, 8'h77);
    wr(IND_WIN_ADDR, 8'hff, BDMM_OP_BCLR, 3'h1);
    wr(NV_CTRL_ADDR, 8'h00);
    rd_chk(IND_WIN_ADDR, 8'h75);
    wr(IND_PTR_ADDR, 8'h80);
    rd_chk(IND_WIN_ADDR, ZERO_BYTE);
    wr(BANK_PTR_ADDR, 8'h00);
    wr(IND_PTR_ADDR, IND_WIN_ADDR);
    wr(IND_WIN_ADDR, 8'hff);
    rd_chk(IND_WIN_ADDR, ZERO_BYTE);
    rd_chk(IND_PTR_ADDR, IND_WIN_ADDR);
    wr(IND_PTR_ADDR, 8'h80);
    wr(IND_WIN_ADDR, 8'h11);
    rd_chk(8'h80, 8'h11);
    wr(BANK_PTR_ADDR, 8'h01);
    wdt_pd_reset_i = 1'b1;
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    wdt_pd_reset_i = 1'b0;
    @(negedge core_clk_i);
    `CHK(bank_sel, 1'b1)
    `CHK(nv_ctrl, NV_CTRL_RST)
    rst_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    `CHK(bank_sel, 1'b0)
    test_done();
  end
  // watchdog: the sequence needs a few microseconds
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : banked_data_memory_map_tb

// [bdmm_core_model.sv]
// processor core model: issues one direct or indirect access per acc call, two per acc2 call
// assumes the map takes a request on a rising edge and answers one cycle later
`timescale 1ns/10ps
module bdmm_core_model (
  input wire logic core_clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic req_valid_o,
  output bdmm_pkg::bdmm_req_t req_o
);
  import bdmm_pkg::*;
  // idle bus from time zero
  initial begin
    req_valid_o = 1'b0;
    req_o = '{rd: 1'b0, op: BDMM_OP_NONE, addr: 8'h00, wdata: 8'h00, bit_sel: 3'h0};
  end
  // one access at the falling edge; window accesses use pointer and bank
  task automatic acc(input logic rd, input bdmm_op_t op, input logic [7:0] a,
                     input logic [7:0] wd, input logic [2:0] b,
                     output logic [7:0] rdat, output logic got);
    @(negedge core_clk_i);
    req_valid_o = 1'b1;
    req_o = '{rd: rd, op: op, addr: a, wdata: wd, bit_sel: b};
    @(negedge core_clk_i);
    got = rvalid_i;
    rdat = rdata_i;
    req_valid_o = 1'b0;
    req_o.addr = ~a; // released bus does not keep its last value
    req_o.wdata = ~wd;
  endtask : acc
  // two accesses on back-to-back edges, both answers taken
  task automatic acc2(input bdmm_req_t r1, input bdmm_req_t r2,
                      output logic [7:0] rdat1, output logic [7:0] rdat2);
    @(negedge core_clk_i);
    req_valid_o = 1'b1;
    req_o = r1;
    @(negedge core_clk_i);
    rdat1 = rdata_i;
    req_o = r2;
    @(negedge core_clk_i);
    rdat2 = rdata_i;
    req_valid_o = 1'b0;
    req_o.addr = ~r2.addr;
    req_o.wdata = ~r2.wdata;
  endtask : acc2
endmodule : bdmm_core_model

// [bdmm_map.sv]
// banked data memory map: decode of special area, ram and bank pointer
// assumes a core that issues one access per cycle; read data one cycle later
`timescale 1ns/10ps
module bdmm_map (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wdt_pd_reset_i,
  input wire logic req_valid_i,
  input wire bdmm_pkg::bdmm_req_t req_i,
  input wire logic [bdmm_pkg::DATA_W-1:0] ro_status_i,
  output logic [bdmm_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic bank_sel_o,
  output logic [bdmm_pkg::DATA_W-1:0] nv_ctrl_o
);
  import bdmm_pkg::*;

  logic bank_select_bit_reg;
  logic [7:0] indirect_pointer_any_bank_reg;
  logic [7:0] nonvolatile_access_control_reg;
  logic [7:0] scratch_reg;
  logic [7:0] eff_addr;
  logic eff_bank;
  logic is_ind;
  logic hit_gp;
  logic hit_nv;
  logic hit_bp;
  logic hit_mp;
  logic hit_ro;
  logic hit_sc;
  logic do_wr;
  logic [7:0] sfr_rd;
  logic [7:0] old_byte;
  logic [7:0] ram_q;
  logic [7:0] sfr_rd_reg;
  logic gp_rd_reg;
  logic ram_we;
  logic [7:0] ram_wd;
  logic [7:0] bank_ptr_next;
  logic wb_we_reg;
  logic [RAM_AW-1:0] wb_addr_reg;
  bdmm_op_t wb_op_reg;
  logic [7:0] wb_wdata_reg;
  logic [2:0] wb_bit_reg;
  logic byp_hit_reg;
  logic [7:0] byp_data_reg;

  // indirect window redirects through the pointer, bank from bank pointer
  always_comb begin
    is_ind = (req_i.addr == IND_WIN_ADDR);
    eff_addr = is_ind ? indirect_pointer_any_bank_reg : req_i.addr;
    eff_bank = is_ind ? bank_select_bit_reg : 1'b0;
    do_wr = req_valid_i && (req_i.op != BDMM_OP_NONE);
  end

  // address decode
  always_comb begin
    hit_gp = 1'b0;
    hit_nv = 1'b0;
    hit_bp = 1'b0;
    hit_mp = 1'b0;
    hit_ro = 1'b0;
    hit_sc = 1'b0;
    if (is_ind && eff_addr == IND_WIN_ADDR) begin
      hit_gp = 1'b0; // window via itself reads zero
    end else if (eff_bank) begin
      hit_nv = (eff_addr == NV_CTRL_ADDR);
    end else if (eff_addr >= GP_BASE) begin
      hit_gp = 1'b1;
    end else if (eff_addr == BANK_PTR_ADDR) begin
      hit_bp = 1'b1;
    end else if (eff_addr == IND_PTR_ADDR) begin
      hit_mp = 1'b1;
    end else if (eff_addr == RO_STAT_ADDR) begin
      hit_ro = 1'b1;
    end else if (eff_addr == SCRATCH_ADDR) begin
      hit_sc = 1'b1;
    end
  end

  // special register read mux, unused reads zero
  always_comb begin
    sfr_rd = ZERO_BYTE;
    if (hit_bp) begin
      sfr_rd = {7'h00, bank_select_bit_reg};
    end else if (hit_mp) begin
      sfr_rd = indirect_pointer_any_bank_reg;
    end else if (hit_ro) begin
      sfr_rd = ro_status_i;
    end else if (hit_sc) begin
      sfr_rd = scratch_reg;
    end else if (hit_nv) begin
      sfr_rd = nonvolatile_access_control_reg;
    end
  end

  // ram request; the byte is merged one cycle later, once its old value is read
  always_comb begin
    ram_we = do_wr && hit_gp;
    old_byte = byp_hit_reg ? byp_data_reg : ram_q; // a write landed on the byte just read
    ram_wd = bdmm_apply(wb_op_reg, old_byte, wb_wdata_reg, wb_bit_reg);
    bank_ptr_next = bdmm_apply(req_i.op, {7'h00, bank_select_bit_reg}, req_i.wdata,
                               req_i.bit_sel);
  end

  // pending ram write, applied at the edge after the request
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wb_we_reg <= 1'b0;
      wb_addr_reg <= '0;
      wb_op_reg <= BDMM_OP_NONE;
      wb_wdata_reg <= ZERO_BYTE;
      wb_bit_reg <= 3'h0;
    end else begin
      wb_we_reg <= ram_we;
      wb_addr_reg <= eff_addr[RAM_AW-1:0];
      wb_op_reg <= req_i.op;
      wb_wdata_reg <= req_i.wdata;
      wb_bit_reg <= req_i.bit_sel;
    end
  end

  // forward a write that lands while the same byte is read, for back-to-back access
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      byp_hit_reg <= 1'b0;
      byp_data_reg <= ZERO_BYTE;
    end else begin
      byp_hit_reg <= wb_we_reg && (wb_addr_reg == eff_addr[RAM_AW-1:0]);
      byp_data_reg <= ram_wd;
    end
  end

  bdmm_ram u_ram (
    .core_clk_i(core_clk_i),
    .we_i(wb_we_reg),
    .waddr_i(wb_addr_reg),
    .wdata_i(ram_wd),
    .raddr_i(eff_addr[RAM_AW-1:0]),
    .rdata_o(ram_q)
  );

  // bank pointer, kept through watchdog power-down reset
  always_ff @(posedge core_clk_i) begin
    if (wdt_pd_reset_i) begin
      bank_select_bit_reg <= bank_select_bit_reg;
    end else if (!rst_n_i) begin
      bank_select_bit_reg <= 1'b0;
    end else if (do_wr && hit_bp) begin
      bank_select_bit_reg <= bank_ptr_next[BANK_BIT];
    end
  end

  // pointer, scratch and nonvolatile control; read-only and unused ignore writes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      indirect_pointer_any_bank_reg <= IND_PTR_RST;
      scratch_reg <= SCRATCH_RST;
      nonvolatile_access_control_reg <= NV_CTRL_RST;
    end else if (do_wr) begin
      if (hit_mp) begin
        indirect_pointer_any_bank_reg <= bdmm_apply(req_i.op, indirect_pointer_any_bank_reg,
                                                    req_i.wdata, req_i.bit_sel);
      end
      if (hit_sc) begin
        scratch_reg <= bdmm_apply(req_i.op, scratch_reg, req_i.wdata, req_i.bit_sel);
      end
      if (hit_nv) begin
        nonvolatile_access_control_reg <= bdmm_apply(req_i.op,
          nonvolatile_access_control_reg, req_i.wdata, req_i.bit_sel);
      end
      // hit_ro and unused addresses fall through untouched
    end
  end

  // read pipeline stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rvalid_o <= 1'b0;
      sfr_rd_reg <= ZERO_BYTE;
      gp_rd_reg <= 1'b0;
    end else begin
      rvalid_o <= req_valid_i && req_i.rd;
      sfr_rd_reg <= sfr_rd;
      gp_rd_reg <= hit_gp;
    end
  end

  // visible state outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bank_sel_o <= 1'b0;
      nv_ctrl_o <= NV_CTRL_RST;
    end else begin
      bank_sel_o <= bank_select_bit_reg;
      nv_ctrl_o <= nonvolatile_access_control_reg;
    end
  end

  assign rdata_o = gp_rd_reg ? old_byte : sfr_rd_reg;

  // assertions
  AST_RO_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    do_wr && (hit_ro || !(hit_gp || hit_bp || hit_mp || hit_sc || hit_nv))
    |=> $stable(indirect_pointer_any_bank_reg) && $stable(scratch_reg)
    && $stable(nonvolatile_access_control_reg) && $stable(bank_select_bit_reg) && !wb_we_reg)
    else $error("write to protected or unused address changed state");
  AST_RAM_FWD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ram_we && req_i.op == BDMM_OP_WRITE ##1 req_valid_i && req_i.rd && hit_gp
    && eff_addr == $past(eff_addr) |=> rdata_o == $past(req_i.wdata, 2))
    else $error("ram write not seen by following read");
  AST_BP_RESET: assert property (@(posedge core_clk_i)
    !rst_n_i && !wdt_pd_reset_i |=> bank_select_bit_reg == 1'b0)
    else $error("bank not cleared by reset");
  AST_BP_WDT: assert property (@(posedge core_clk_i)
    wdt_pd_reset_i |=> $stable(bank_select_bit_reg))
    else $error("bank changed by watchdog power-down reset");
  AST_DIRECT_B0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    do_wr && !is_ind && req_i.addr == NV_CTRL_ADDR |=> $stable(nonvolatile_access_control_reg))
    else $error("direct access left bank 0");
  AST_BP_READ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.rd && hit_bp |=> rvalid_o && rdata_o[7:1] == 7'h00)
    else $error("bank pointer upper bits nonzero");
  AST_UNUSED_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.rd && !(hit_gp || hit_bp || hit_mp || hit_ro || hit_sc || hit_nv)
    |=> rdata_o == ZERO_BYTE)
    else $error("unused address read nonzero");
  AST_NV_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.op == BDMM_OP_WRITE && hit_nv
    |=> nonvolatile_access_control_reg == $past(req_i.wdata))
    else $error("nonvolatile control write lost");
  AST_NV_ONLY_B1: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hit_nv |-> is_ind && bank_select_bit_reg)
    else $error("bank 1 reached without indirect path");
  AST_MP_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.op == BDMM_OP_WRITE && hit_mp
    |=> indirect_pointer_any_bank_reg == $past(req_i.wdata))
    else $error("pointer write lost");
  COV_IND_B1: cover property (@(posedge core_clk_i) req_valid_i && hit_nv);
  COV_GP_BSET: cover property (@(posedge core_clk_i) ram_we && req_i.op == BDMM_OP_BSET);
  COV_WDT_KEEP: cover property (@(posedge core_clk_i) wdt_pd_reset_i && bank_select_bit_reg);
  COV_B2B_FWD: cover property (@(posedge core_clk_i) byp_hit_reg && gp_rd_reg);
endmodule : bdmm_map

// [bdmm_pkg.sv]
// package of constants and carrier types for the banked data memory map
// assumes the core presents one access per clock, byte wide
// Operation
// - data memory is volatile byte-wide ram
// - special registers 00h-7fh reached in bank 0
// - bank 1 address 40h is nonvolatile control
// - 128 ram bytes at 80h-ffh bank 0
// - bank pointer selects the accessed bank
// - unused special addresses read as zero
// - protected special registers ignore writes
// - ram supports byte and single-bit operations
// - pointer bit 0 selects bank, others zero
// - direct accesses always reach bank 0
// - reset clears bank except watchdog power-down
// - bank 1 only via indirect pointer path
package bdmm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RAM_DEPTH = 128;
  localparam int unsigned RAM_AW = 7;
  localparam logic [7:0] GP_BASE = 8'h80;
  localparam logic [7:0] NV_CTRL_ADDR = 8'h40;
  localparam logic [7:0] BANK_PTR_ADDR = 8'h04;
  localparam logic [7:0] IND_WIN_ADDR = 8'h02;
  localparam logic [7:0] IND_PTR_ADDR = 8'h03;
  localparam logic [7:0] RO_STAT_ADDR = 8'h05;
  localparam logic [7:0] SCRATCH_ADDR = 8'h06;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] NV_CTRL_RST = 8'h00;
  localparam logic [7:0] IND_PTR_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam int unsigned BANK_BIT = 0;

  typedef enum logic [3:0] {
    BDMM_OP_NONE = 4'h1,
    BDMM_OP_WRITE = 4'h2,
    BDMM_OP_BSET = 4'h4,
    BDMM_OP_BCLR = 4'h8
  } bdmm_op_t;

  // one core access; addr equal to IND_WIN_ADDR marks use of the any-bank window
  typedef struct packed {
    logic rd;
    bdmm_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [2:0] bit_sel;
  } bdmm_req_t;

  // merge a byte with a write, bit-set or bit-clear
  function automatic logic [7:0] bdmm_apply(input bdmm_op_t op, input logic [7:0] old,
                                            input logic [7:0] wd, input logic [2:0] b);
    logic [7:0] m;
    m = 8'h01 << b;
    case (op)
      BDMM_OP_WRITE: bdmm_apply = wd;
      BDMM_OP_BSET: bdmm_apply = old | m;
      BDMM_OP_BCLR: bdmm_apply = old & ~m;
      default: bdmm_apply = old;
    endcase
  endfunction : bdmm_apply
endpackage : bdmm_pkg

// [bdmm_ram.sv]
// general purpose ram, 128 bytes, registered read data
// assumes read and write never target the same cycle result
`timescale 1ns/10ps
module bdmm_ram (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic [bdmm_pkg::RAM_AW-1:0] waddr_i,
  input wire logic [bdmm_pkg::DATA_W-1:0] wdata_i,
  input wire logic [bdmm_pkg::RAM_AW-1:0] raddr_i,
  output logic [bdmm_pkg::DATA_W-1:0] rdata_o
);
  import bdmm_pkg::*;
  logic [DATA_W-1:0] mem [RAM_DEPTH]; // volatile, no reset

  // write port
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge core_clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : bdmm_ram
